// *** rtl/uac_attach_control.sv ***
// Attach and power-state control for a full-speed USB peripheral port:
// pull-up control, VBUS sensing, detach and wake lines, power limits.
// Assumes a USB protocol core on the same clock and an Avalon-MM master.
`timescale 1ns/1ps
`default_nettype none
module uac_attach_control #(
	parameter int PINS = 16
) (
	// Clock and reset
	input  wire logic                          clock,
	input  wire logic                          rst_n,
	// Avalon-MM slave
	input  wire logic [uac_pkg::ADDR_W-1:0]    address,
	input  wire logic                          read,
	input  wire logic                          write,
	input  wire logic [uac_pkg::DATA_W-1:0]    writedata,
	output logic      [uac_pkg::DATA_W-1:0]    readdata,
	output logic                               waitrequest,
	output logic                               irq,
	// USB protocol core
	input  wire logic                          coreTxEnable,
	input  wire logic                          coreTxPlus,
	input  wire logic                          coreTxMinus,
	input  wire logic                          busSuspend,
	input  wire logic                          busConfigured,
	output logic                               busReattach,
	output logic                               audioEndpointSet,
	output logic      [7:0]                    descriptorMaxPower,
	// USB data pins
	output logic                               dataPlusOut,
	output logic                               dataPlusOe_n,
	output logic                               dataMinusOut,
	output logic                               dataMinusOe_n,
	output logic                               internalPullupEn,
	// General pins
	input  wire logic [PINS-1:0]               generalIoIn,
	output logic      [PINS-1:0]               generalIoOut,
	output logic      [PINS-1:0]               generalIoOe_n,
	// Power management
	output logic      [1:0]                    currentLimit,
	output logic                               radioEnable
);
	import uac_pkg::*;

	// ************************************************************
	// Declarations
	// ************************************************************
	uac_sense_if sense ();

	logic [CTL_W-1:0]     control_q;
	logic [PIN_SEL_W-1:0] vbusSel_q;
	logic [PIN_SEL_W-1:0] detachSel_q;
	logic [PIN_SEL_W-1:0] wakeSel_q;
	logic [PIN_SEL_W-1:0] pullupSel_q;
	logic [7:0]           maxPower_q;
	logic [INT_W-1:0]     intStatus_q, intStatus_d, intMask_q, events;
	logic                 ack_q, wrTake, rdTake;
	logic [31:0]          rdValue, statusWord;
	uac_attach_e          state_q, state_d;
	logic                 vbusPrev_q, detachPrev_q, suspendPrev_q, configPrev_q;
	logic                 applied, selfPowered, pullupOn, detached, vbusOk, wakeOn;
	assign applied     = control_q[CTL_APPLIED];
	assign selfPowered = control_q[CTL_SELF_PWR];
	assign vbusOk      = !selfPowered || sense.vbusSense;
	assign detached    = (state_q == ATT_DETACHED);
	// ************************************************************
	// Pin sampling
	// ************************************************************
	assign sense.vbusSel   = vbusSel_q;
	assign sense.detachSel = detachSel_q;

	uac_pin_sampler #(
		.PINS        (PINS)
	) u_sampler (
		.clock       (clock),
		.rst_n       (rst_n),
		.generalIoIn (generalIoIn),
		.sense       (sense)
	);

	// ************************************************************
	// Avalon-MM handshake
	// ************************************************************
	// One wait cycle: answer on the edge after the request appears
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (read || write) && !ack_q;
		end
	end
	assign waitrequest = (read || write) && !ack_q;
	assign wrTake      = write && ack_q;
	assign rdTake      = read && ack_q;
	// Status word assembled from live state
	always_comb begin
		statusWord                                = 32'h0000_0000;
		statusWord[ST_VBUS]                       = sense.vbusSense;
		statusWord[ST_DETACHED]                   = detached;
		statusWord[ST_PULLUP]                     = pullupOn;
		statusWord[ST_SUSPENDED]                  = busSuspend;
		statusWord[ST_CONFIGURED]                 = busConfigured;
		statusWord[ST_RADIO]                      = radioEnable;
		statusWord[ST_LIMIT_LSB+1:ST_LIMIT_LSB]   = currentLimit;
	end

	// Read multiplexer, unmapped offsets read zero
	always_comb begin
		rdValue = 32'h0000_0000;
		case (address)
			OFF_CONTROL:    rdValue[CTL_W-1:0] = control_q;
			OFF_PIN_SELECT: begin
				rdValue[PS_VBUS_LSB+:PIN_SEL_W]   = vbusSel_q;
				rdValue[PS_DETACH_LSB+:PIN_SEL_W] = detachSel_q;
				rdValue[PS_WAKE_LSB+:PIN_SEL_W]   = wakeSel_q;
				rdValue[PS_PULLUP_LSB+:PIN_SEL_W] = pullupSel_q;
			end
			OFF_MAX_POWER:  rdValue[7:0] = maxPower_q;
			OFF_STATUS:     rdValue = statusWord;
			OFF_INT_STATUS: rdValue[INT_W-1:0] = intStatus_q;
			OFF_INT_MASK:   rdValue[INT_W-1:0] = intMask_q;
			default:        rdValue = 32'h0000_0000;
		endcase
	end
	// Read data captured in the wait cycle, held through the answer
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			readdata <= 32'h0000_0000;
		end else if (read && !ack_q) begin
			readdata <= rdValue;
		end
	end

	// ************************************************************
	// Configuration registers
	// ************************************************************
	// Control bits; wake request also drops when detach is released
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			control_q <= CONTROL_RST;
		end else if (wrTake && address == OFF_CONTROL) begin
			control_q <= writedata[CTL_W-1:0];
		end else if (detachPrev_q && !sense.detachSense) begin
			control_q[CTL_WAKE_REQ] <= 1'b0;
		end
	end

	// Pin number fields
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			vbusSel_q   <= VBUS_PIN_RST;
			detachSel_q <= DETACH_PIN_RST;
			wakeSel_q   <= WAKE_PIN_RST;
			pullupSel_q <= PULLUP_PIN_RST;
		end else if (wrTake && address == OFF_PIN_SELECT) begin
			vbusSel_q   <= writedata[PS_VBUS_LSB+:PIN_SEL_W];
			detachSel_q <= writedata[PS_DETACH_LSB+:PIN_SEL_W];
			wakeSel_q   <= writedata[PS_WAKE_LSB+:PIN_SEL_W];
			pullupSel_q <= writedata[PS_PULLUP_LSB+:PIN_SEL_W];
		end
	end

	// Descriptor max power setting
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			maxPower_q <= MAX_POWER_RST;
		end else if (wrTake && address == OFF_MAX_POWER) begin
			maxPower_q <= writedata[7:0];
		end
	end

	// Interrupt mask
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			intMask_q <= INT_RST;
		end else if (wrTake && address == OFF_INT_MASK) begin
			intMask_q <= writedata[INT_W-1:0];
		end
	end

	// ************************************************************
	// Events and interrupt
	// ************************************************************
	// Previous levels for edge detection
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			vbusPrev_q    <= 1'b0;
			detachPrev_q  <= 1'b0;
			suspendPrev_q <= 1'b0;
			configPrev_q  <= 1'b0;
		end else begin
			vbusPrev_q    <= sense.vbusSense;
			detachPrev_q  <= sense.detachSense;
			suspendPrev_q <= busSuspend;
			configPrev_q  <= busConfigured;
		end
	end
	assign events[EV_VBUS_CHG]   = vbusPrev_q != sense.vbusSense;
	assign events[EV_DETACH_ON]  = !detachPrev_q && sense.detachSense;
	assign events[EV_DETACH_OFF] = detachPrev_q && !sense.detachSense;
	assign events[EV_SUSPEND]    = !suspendPrev_q && busSuspend;
	assign events[EV_CONFIGURED] = !configPrev_q && busConfigured;
	// Read clears the sticky bits; a new event in that cycle wins
	assign intStatus_d = ((rdTake && address == OFF_INT_STATUS) ? '0 : intStatus_q) | events;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			intStatus_q <= INT_RST;
		end else begin
			intStatus_q <= intStatus_d;
		end
	end

	assign irq = |(intStatus_q & intMask_q);

	// ************************************************************
	// Attach state machine
	// ************************************************************
	// Every state obeys one priority: configuration, then detach, then VBUS
	always_comb begin
		case (state_q)
			ATT_WAIT_CFG, ATT_NO_VBUS, ATT_DETACHED, ATT_ATTACHED: begin
				if (!applied) begin
					state_d = ATT_WAIT_CFG;
				end else if (sense.detachSense) begin
					state_d = ATT_DETACHED;
				end else if (!vbusOk) begin
					state_d = ATT_NO_VBUS;
				end else begin
					state_d = ATT_ATTACHED;
				end
			end
			default: begin
				state_d = ATT_WAIT_CFG;
			end
		endcase
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_q <= ATT_WAIT_CFG;
		end else begin
			state_q <= state_d;
		end
	end

	// Pulse to the core: bus reset state, await enumeration again
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			busReattach <= 1'b0;
		end else begin
			busReattach <= (state_q == ATT_DETACHED) && (state_d == ATT_ATTACHED);
		end
	end

	// ************************************************************
	// Pin drive
	// ************************************************************
	assign pullupOn = (state_q == ATT_ATTACHED);
	assign wakeOn   = detached && control_q[CTL_WAKE_REQ];

	// Data lines driven only while attached and the core answers
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			dataPlusOut      <= 1'b0;
			dataMinusOut     <= 1'b0;
			dataPlusOe_n     <= 1'b1;
			dataMinusOe_n    <= 1'b1;
			internalPullupEn <= 1'b0;
		end else begin
			dataPlusOut      <= coreTxPlus;
			dataMinusOut     <= coreTxMinus;
			dataPlusOe_n     <= !(pullupOn && coreTxEnable);
			dataMinusOe_n    <= !(pullupOn && coreTxEnable);
			internalPullupEn <= pullupOn && !control_q[CTL_PULLUP_SRC];
		end
	end

	// Wake pin and external pull-up pin; others stay inputs
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			generalIoOut  <= '0;
			generalIoOe_n <= '1;
		end else begin
			for (int i = 0; i < PINS; i++) begin
				if (applied && i == int'(wakeSel_q)) begin
					generalIoOut[i]  <= wakeOn;
					generalIoOe_n[i] <= 1'b0;
				end else if (control_q[CTL_PULLUP_SRC] && i == int'(pullupSel_q)) begin
					generalIoOut[i]  <= 1'b1;
					generalIoOe_n[i] <= !pullupOn;
				end else begin
					generalIoOut[i]  <= 1'b0;
					generalIoOe_n[i] <= 1'b1;
				end
			end
		end
	end

	// ************************************************************
	// Power management
	// ************************************************************
	// Limit class and radio gate
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			currentLimit <= LIM_100MA;
			radioEnable  <= 1'b0;
		end else begin
			currentLimit <= selfPowered   ? LIM_SELF :
			                busSuspend    ? LIM_SUSPEND :
			                busConfigured ? LIM_500MA : LIM_100MA;
			radioEnable <= applied && (selfPowered || !busSuspend);
		end
	end
	// Descriptor and endpoint personality toward the core
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			descriptorMaxPower <= MAX_POWER_RST;
			audioEndpointSet   <= 1'b0;
		end else begin
			descriptorMaxPower <= maxPower_q;
			audioEndpointSet   <= control_q[CTL_EP_SET];
		end
	end
endmodule
`default_nettype wire

// *** rtl/uac_pkg.sv ***
// Shared constants for the USB attach controller: register map, field
// positions, reset values and the attach state enumeration.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package uac_pkg;

	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int          PIN_SEL_W      = 4;   // Width of a pin number field
	localparam int          ADDR_W         = 5;   // Byte address width
	localparam int          DATA_W         = 32;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [4:0]  OFF_CONTROL    = 5'h00;
	localparam logic [4:0]  OFF_PIN_SELECT = 5'h04;
	localparam logic [4:0]  OFF_MAX_POWER  = 5'h08;
	localparam logic [4:0]  OFF_STATUS     = 5'h0C;
	localparam logic [4:0]  OFF_INT_STATUS = 5'h10;
	localparam logic [4:0]  OFF_INT_MASK   = 5'h14;

	// ************************************************************
	// Control register fields
	// ************************************************************
	localparam int          CTL_APPLIED    = 0;   // Configuration loaded and applied
	localparam int          CTL_PULLUP_SRC = 1;   // 0 internal, 1 external via pin
	localparam int          CTL_SELF_PWR   = 2;   // 1 self-powered, 0 bus-powered
	localparam int          CTL_EP_SET     = 3;   // 0 host-interface set, 1 audio set
	localparam int          CTL_WAKE_REQ   = 4;   // Request out-of-band wake
	localparam int          CTL_W          = 5;
	localparam logic [4:0]  CONTROL_RST    = 5'h00;

	// ************************************************************
	// Pin select fields (LSB positions)
	// ************************************************************
	localparam int          PS_VBUS_LSB    = 0;
	localparam int          PS_DETACH_LSB  = 8;
	localparam int          PS_WAKE_LSB    = 16;
	localparam int          PS_PULLUP_LSB  = 24;
	localparam logic [3:0]  VBUS_PIN_RST   = 4'h0;
	localparam logic [3:0]  DETACH_PIN_RST = 4'h1;
	localparam logic [3:0]  WAKE_PIN_RST   = 4'h2;
	localparam logic [3:0]  PULLUP_PIN_RST = 4'h3;

	// ************************************************************
	// Max power: descriptor counts in 2 mA units, 300 mA default
	// ************************************************************
	localparam int          MAX_POWER_DEF_MA = 300;
	localparam int          MAX_POWER_UNIT_MA = 2;
	localparam logic [7:0]  MAX_POWER_RST  = 8'(MAX_POWER_DEF_MA / MAX_POWER_UNIT_MA);

	// ************************************************************
	// Status and interrupt fields
	// ************************************************************
	localparam int          ST_VBUS        = 0;
	localparam int          ST_DETACHED    = 1;
	localparam int          ST_PULLUP      = 2;
	localparam int          ST_SUSPENDED   = 3;
	localparam int          ST_CONFIGURED  = 4;
	localparam int          ST_RADIO       = 5;
	localparam int          ST_LIMIT_LSB   = 8;
	localparam int          INT_W          = 5;
	localparam int          EV_VBUS_CHG    = 0;
	localparam int          EV_DETACH_ON   = 1;
	localparam int          EV_DETACH_OFF  = 2;
	localparam int          EV_SUSPEND     = 3;
	localparam int          EV_CONFIGURED  = 4;
	localparam logic [4:0]  INT_RST        = 5'h00;

	// ************************************************************
	// Current limit classes
	// ************************************************************
	localparam logic [1:0]  LIM_100MA      = 2'h0;  // Bus-powered, not configured
	localparam logic [1:0]  LIM_500MA      = 2'h1;  // Bus-powered, configured
	localparam logic [1:0]  LIM_SUSPEND    = 2'h2;  // Bus-powered suspend, 2.5 mA
	localparam logic [1:0]  LIM_SELF       = 2'h3;  // Self-powered, bus draw is leakage

	typedef enum logic [1:0] {
		ATT_WAIT_CFG,
		ATT_NO_VBUS,
		ATT_DETACHED,
		ATT_ATTACHED
	} uac_attach_e;

endpackage

// *** rtl/uac_sense_if.sv ***
// Carrier between the attach controller and its pin sampler.
// Assumes both ends run on the one system clock.
`timescale 1ns/1ps
`default_nettype none
interface uac_sense_if;
	logic [uac_pkg::PIN_SEL_W-1:0] vbusSel;
	logic [uac_pkg::PIN_SEL_W-1:0] detachSel;
	logic                          vbusSense;
	logic                          detachSense;

	modport sampler (input vbusSel, input detachSel, output vbusSense, output detachSense);
	modport control (output vbusSel, output detachSel, input vbusSense, input detachSense);
endinterface
`default_nettype wire

// *** rtl/uac_pin_sampler.sv ***
// Two-stage synchroniser for the general pins and the selectors that pick
// the VBUS sense and detach levels out of them.
// Assumes pin numbers below PINS; larger numbers read as low.
`timescale 1ns/1ps
`default_nettype none
module uac_pin_sampler #(
	parameter int PINS = 16
) (
	// Clock and reset
	input  wire logic            clock,
	input  wire logic            rst_n,
	// Raw pins
	input  wire logic [PINS-1:0] generalIoIn,
	// Selected levels
	uac_sense_if.sampler         sense
);
	import uac_pkg::*;

	logic [PINS-1:0] meta_q;
	logic [PINS-1:0] sync_q;

	// Two flip-flops before anything reads a pin
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= generalIoIn;
			sync_q <= meta_q;
		end
	end

	// Registered pick of the selected pins
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sense.vbusSense   <= 1'b0;
			sense.detachSense <= 1'b0;
		end else begin
			sense.vbusSense   <= (int'(sense.vbusSel) < PINS) ? sync_q[sense.vbusSel] : 1'b0;
			sense.detachSense <= (int'(sense.detachSel) < PINS) ? sync_q[sense.detachSel] : 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** verification/uac_host_model.sv ***
// Behavioural far side: a host port that enumerates after attach.
// Assumes the bench clock and the attach pull-up level as seen on D+.
`timescale 1ns/1ps
`default_nettype none
module uac_host_model (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// Bus view
	input  wire logic pullupSeen,
	input  wire logic suspendReq,
	// Core levels
	output logic      busConfigured,
	output var logic  busSuspend
);
	logic [4:0] seen_q;
	// Host enumerates only after the pull-up has stood 16 cycles
	always_ff @(posedge clock) begin
		if (!rst_n || !pullupSeen) begin
			seen_q <= 5'h00;
		end else if (seen_q != 5'h10) begin
			seen_q <= seen_q + 5'h01;
		end
	end
	assign busConfigured = (seen_q == 5'h10);
	// Host suspends only a configured device
	always_ff @(posedge clock) begin
		busSuspend <= rst_n && suspendReq && busConfigured;
	end
endmodule
`default_nettype wire

// *** verification/uac_attach_control_props.sv ***
// Checks on the attach controller's top-level ports.
// Assumes one system clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module uac_attach_control_props #(
	parameter int PINS = 16
) (
	input wire logic                       clock,
	input wire logic                       rst_n,
	input wire logic [uac_pkg::ADDR_W-1:0] address,
	input wire logic                       read,
	input wire logic                       write,
	input wire logic [uac_pkg::DATA_W-1:0] writedata,
	input wire logic                       waitrequest,
	input wire logic                       coreTxEnable,
	input wire logic                       busConfigured,
	input wire logic                       busReattach,
	input wire logic                       audioEndpointSet,
	input wire logic [7:0]                 descriptorMaxPower,
	input wire logic                       dataPlusOe_n,
	input wire logic                       dataMinusOe_n,
	input wire logic                       internalPullupEn,
	input wire logic [PINS-1:0]            generalIoIn,
	input wire logic [PINS-1:0]            generalIoOut,
	input wire logic [1:0]                 currentLimit,
	input wire logic                       radioEnable
);
	import uac_pkg::*;
	logic       ack;
	logic [7:0] mp_q;
	logic       ep_q;
	logic [3:0] detSel_q;
	logic [3:0] wakeSel_q;
	logic [2:0] hi_q;
	logic [2:0] lo_q;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// ************************************************************
	// Shadow state
	// ************************************************************
	assign ack = write && !waitrequest;
	// Shadow of fields written over the bus
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mp_q      <= MAX_POWER_RST;
			ep_q      <= 1'b0;
			detSel_q  <= DETACH_PIN_RST;
			wakeSel_q <= WAKE_PIN_RST;
		end else if (ack && address == OFF_MAX_POWER) begin
			mp_q <= writedata[7:0];
		end else if (ack && address == OFF_CONTROL) begin
			ep_q <= writedata[CTL_EP_SET];
		end else if (ack && address == OFF_PIN_SELECT) begin
			detSel_q  <= writedata[PS_DETACH_LSB +: 4];
			wakeSel_q <= writedata[PS_WAKE_LSB +: 4];
		end
	end
	// Run length of the detach pin level, restarted by any write
	always_ff @(posedge clock) begin
		if (!rst_n || ack) begin
			hi_q <= 3'h0;
			lo_q <= 3'h0;
		end else begin
			hi_q <= !generalIoIn[detSel_q] ? 3'h0 : (hi_q == 3'h7) ? hi_q : hi_q + 3'h1;
			lo_q <= generalIoIn[detSel_q] ? 3'h0 : (lo_q == 3'h7) ? lo_q : lo_q + 3'h1;
		end
	end
	// ************************************************************
	// Assertions
	// ************************************************************
	a_tx_drive_only: assert property ((!dataPlusOe_n || !dataMinusOe_n) |-> $past(coreTxEnable))
		else $error("data line driven without core transmit");
	a_lines_paired: assert property (dataPlusOe_n == dataMinusOe_n)
		else $error("data line enables differ");
	a_bus_one_wait: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
		else $error("bus answer not after one wait cycle");
	a_power_field: assert property (ack && address == OFF_MAX_POWER |-> ##[1:2] descriptorMaxPower == mp_q)
		else $error("descriptor power not updated");
	a_endpoint_set: assert property (ack && address == OFF_CONTROL |-> ##[1:2] audioEndpointSet == ep_q)
		else $error("endpoint set not updated");
	a_limit_configured: assert property (currentLimit == LIM_500MA |-> $past(busConfigured) || $past(busConfigured, 2))
		else $error("high limit before configuration");
	a_suspend_radio: assert property (currentLimit == LIM_SUSPEND |-> !radioEnable)
		else $error("radio on in suspend");
	a_detach_off: assert property (hi_q == 3'h7 |-> !internalPullupEn && dataPlusOe_n)
		else $error("still attached while detach held");
	a_wake_detached: assert property (lo_q == 3'h7 |-> !generalIoOut[wakeSel_q])
		else $error("wake high while attached");
	a_reattach_pulse: assert property (busReattach |=> !busReattach)
		else $error("reattach pulse too long");
endmodule
bind uac_attach_control uac_attach_control_props #(.PINS(PINS)) u_props (
	.clock, .rst_n, .address, .read, .write, .writedata, .waitrequest, .coreTxEnable,
	.busConfigured, .busReattach, .audioEndpointSet, .descriptorMaxPower, .dataPlusOe_n,
	.dataMinusOe_n, .internalPullupEn, .generalIoIn, .generalIoOut, .currentLimit, .radioEnable
);
`default_nettype wire

// *** verification/uac_attach_control_bench.sv ***
// Self-checking bench for the attach controller with a host model.
// Assumes the default pin map: vbus 0, detach 1, wake 2, pull-up 3.
`timescale 1ns/1ps
`default_nettype none
module uac_attach_control_bench;
	import uac_pkg::*;
	logic        clock, rst_n, read, write, waitrequest, irq;
	logic        coreTxEnable, coreTxPlus, coreTxMinus, busSuspend, busConfigured;
	logic        busReattach, audioEndpointSet, suspendReq, radioEnable, pullupSeen;
	logic        dataPlusOut, dataPlusOe_n, dataMinusOut, dataMinusOe_n, internalPullupEn;
	logic [4:0]  address;
	logic [31:0] writedata, readdata, q;
	logic [7:0]  descriptorMaxPower;
	logic [15:0] gpIn, gpOut, gpOe_n, pins;
	logic [1:0]  currentLimit;
	int          mismatches = 0;
	int          samplesChecked = 0;
	int          n;
	// Pin levels: design drive wins, else the bench level
	assign gpIn = (~gpOe_n & gpOut) | (gpOe_n & pins);
	assign pullupSeen = internalPullupEn || (!gpOe_n[3] && gpOut[3]);
	uac_attach_control u_dut (.clock, .rst_n, .address, .read, .write, .writedata, .readdata,
		.waitrequest, .irq, .coreTxEnable, .coreTxPlus, .coreTxMinus, .busSuspend, .busConfigured,
		.busReattach, .audioEndpointSet, .descriptorMaxPower, .dataPlusOut, .dataPlusOe_n,
		.dataMinusOut, .dataMinusOe_n, .internalPullupEn, .generalIoIn(gpIn), .generalIoOut(gpOut),
		.generalIoOe_n(gpOe_n), .currentLimit, .radioEnable);
	uac_host_model u_host (.clock, .rst_n, .pullupSeen, .suspendReq, .busConfigured, .busSuspend);
	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		samplesChecked++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samplesChecked, mismatches);
		if (mismatches == 0 && samplesChecked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// One Avalon transfer, held until a rising edge samples waitrequest low
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		@(posedge clock);
		address   <= a;
		writedata <= d;
		write     <= w;
		read      <= !w;
		do @(posedge clock); while (waitrequest !== 1'b0);
		q = readdata;
		write <= 1'b0;
		read  <= 1'b0;
	endtask
	task automatic pin(input int i, input logic v);
		@(posedge clock);
		pins[i] <= v;
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge clock);
		@(negedge clock);
	endtask
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset();
		bus(1'b0, OFF_PIN_SELECT, 32'h0); chk("pin select", q, 32'h03020100);
		bus(1'b0, OFF_MAX_POWER, 32'h0); chk("max power", q, 32'h00000096);
		bus(1'b0, 5'h18, 32'h0); chk("unmapped", q, 32'h0);
		chk("pull-up", internalPullupEn, 1'b0);
		chk("pin enables", gpOe_n, 16'hFFFF);
		$display("test reset done");
	endtask
	task automatic t_attach();
		bus(1'b1, OFF_MAX_POWER, 32'h32);
		bus(1'b1, OFF_CONTROL, 32'h9);
		@(posedge clock) {coreTxEnable, coreTxPlus} <= 2'h3;
		settle(8); chk("pull-up", internalPullupEn, 1'b1);
		chk("audio set", audioEndpointSet, 1'b1);
		chk("descriptor", descriptorMaxPower, 8'h32);
		chk("limit early", currentLimit, LIM_100MA);
		chk("drive", {dataPlusOe_n, dataMinusOe_n, dataPlusOut, dataMinusOut}, 4'h2);
		settle(16); chk("limit late", currentLimit, LIM_500MA);
		bus(1'b1, OFF_CONTROL, 32'h1); settle(4); chk("audio set", audioEndpointSet, 1'b0);
		$display("test attach done");
	endtask
	task automatic t_detach();
		bus(1'b1, OFF_INT_MASK, 32'h0);
		bus(1'b0, OFF_INT_STATUS, 32'h0);
		bus(1'b1, OFF_CONTROL, 32'h11);
		pin(1, 1'b1); settle(8);
		chk("line enables", {internalPullupEn, dataPlusOe_n, dataMinusOe_n}, 3'h3);
		chk("wake", {gpOut[2], gpOe_n[2]}, 2'h2);
		chk("masked irq", irq, 1'b0);
		bus(1'b1, OFF_INT_MASK, 32'h2); @(negedge clock); chk("irq", irq, 1'b1);
		bus(1'b0, OFF_INT_STATUS, 32'h0); chk("detach event", q & 32'h2, 32'h2);
		@(negedge clock); chk("irq cleared", irq, 1'b0);
		pin(1, 1'b0); n = 0;
		repeat (12) begin
			@(negedge clock);
			if (busReattach === 1'b1) n++;
		end
		chk("reattach pulses", 32'(n), 32'h1);
		chk("pull-up back", internalPullupEn, 1'b1);
		chk("wake low", gpOut[2], 1'b0);
		$display("test detach done");
	endtask
	task automatic t_self();
		bus(1'b1, OFF_CONTROL, 32'h7);
		pin(0, 1'b0); settle(8); chk("internal off", internalPullupEn, 1'b0);
		chk("no vbus", gpOe_n[3], 1'b1);
		pin(0, 1'b1); settle(8); chk("ext pull-up", {gpOe_n[3], gpOut[3]}, 2'h1);
		bus(1'b1, OFF_PIN_SELECT, 32'h03020105); settle(8); chk("vbus pin", gpOe_n[3], 1'b1);
		bus(1'b1, OFF_PIN_SELECT, 32'h03020700); pin(7, 1'b1); settle(8);
		chk("detach pin", gpOe_n[3], 1'b1);
		pin(7, 1'b0); settle(8); chk("detach pin", gpOe_n[3], 1'b0);
		$display("test self-powered done");
	endtask
	task automatic t_suspend();
		bus(1'b1, OFF_CONTROL, 32'h1); settle(30);
		bus(1'b0, OFF_INT_STATUS, 32'h0);
		@(posedge clock) suspendReq <= 1'b1;
		settle(8); chk("suspend", {currentLimit, radioEnable}, {LIM_SUSPEND, 1'b0});
		bus(1'b0, OFF_INT_STATUS, 32'h0); chk("suspend event", q & 32'h8, 32'h8);
		bus(1'b0, OFF_STATUS, 32'h0); chk("status", q, 32'h0000021D);
		@(posedge clock) suspendReq <= 1'b0;
		$display("test suspend done");
	endtask
	// Clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// Watchdog for a hung run
	initial begin
		repeat (20000) @(posedge clock);
		mismatches++;
		wrap_up();
	end
	// Main sequence
	initial begin
		{rst_n, read, write, coreTxEnable, coreTxPlus, coreTxMinus, suspendReq} = 7'h0;
		address = 5'h00;
		writedata = 32'h0;
		pins = 16'h0001;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		t_reset();
		t_attach();
		t_detach();
		t_self();
		t_suspend();
		wrap_up();
	end
endmodule
`default_nettype wire
